// >>> core/mbd_pkg.sv
// Constants, codes and carrier types for the drive data map.
package mbd_pkg;

  // ==========================================================================
  // Function, diagnostic sub-function and exception codes
  localparam logic [7:0] FC_RD_COILS = 8'h01;
  localparam logic [7:0] FC_RD_HOLD = 8'h03;
  localparam logic [7:0] FC_WR_COIL = 8'h05;
  localparam logic [7:0] FC_WR_REG = 8'h06;
  localparam logic [7:0] FC_DIAG = 8'h08;
  localparam logic [7:0] FC_EVT_CNT = 8'h0b;
  localparam logic [7:0] FC_WR_COILS = 8'h0f;
  localparam logic [7:0] FC_WR_REGS = 8'h10;
  localparam logic [7:0] FC_SLAVE_ID = 8'h11;
  localparam logic [7:0] FC_EXC_FLAG = 8'h80;
  localparam logic [15:0] SUB_RESTART = 16'h0001;
  localparam logic [15:0] SUB_DIAG_REG = 16'h0002;
  localparam logic [15:0] SUB_CLEAR = 16'h000a;
  localparam logic [15:0] SUB_BUS_MSG = 16'h000b;
  localparam logic [15:0] SUB_BUS_ERR = 16'h000c;
  localparam logic [15:0] SUB_EXC_CNT = 16'h000d;
  localparam logic [15:0] SUB_SLV_MSG = 16'h000e;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [7:0] EXC_DEVICE = 8'h04;

  // ==========================================================================
  // Coil map, zero-based bit positions
  localparam int COIL_COUNT = 65;
  localparam int COIL_CMD_LSB = 0;
  localparam int COIL_REF_LSB = 16;
  localparam int COIL_STW_LSB = 32;
  localparam int COIL_MAV_LSB = 48;
  localparam int COIL_STORE = 64;
  localparam logic [16:0] COIL_END = 17'h00041;
  localparam logic [4:0] COIL_ITEM_MAX = 5'h10;
  localparam logic [15:0] COIL_ON = 16'hff00;
  localparam logic [15:0] COIL_OFF = 16'h0000;
  localparam logic [15:0] STW_USED_MASK = 16'hef8f;
  localparam int STW_RUNNING = 11;

  // ==========================================================================
  // Holding register numbers (message address is number minus one)
  localparam logic [15:0] REG_ERR = 16'h0007;
  localparam logic [15:0] REG_INDEX = 16'h0009;
  localparam logic [15:0] REG_PAR_FIRST = 16'h000a;
  localparam logic [15:0] REG_CMD = 16'hc350;
  localparam logic [15:0] REG_REF = 16'hc35a;
  localparam logic [15:0] REG_STW = 16'hc418;
  localparam logic [15:0] REG_MAV = 16'hc422;
  localparam logic [16:0] REG_END = 17'h0c422;
  localparam logic [15:0] PAR_SCALE = 16'h000a;

  // ==========================================================================
  // Carrier types
  typedef struct packed {
    logic [7:0] func;
    logic [15:0] addr;
    logic [15:0] qty;
    logic [15:0] data;
  } mbd_req_t;

  typedef struct packed {
    logic exc;
    logic [7:0] code;
    logic [7:0] func;
    logic [15:0] data;
  } mbd_rsp_t;

  typedef struct packed {
    logic reverse;
    logic [1:0] setup_sel;
    logic relay2_on;
    logic relay1_on;
    logic data_valid;
    logic ramp2;
    logic jog;
    logic fault_reset;
    logic start;
    logic no_freeze;
    logic no_quick_stop;
    logic no_coast;
    logic no_dc_brake;
    logic [1:0] preset_sel;
  } mbd_cmd_t;

  typedef struct packed {
    logic write;
    logic store_nv;
    logic [15:0] num;
    logic [15:0] index;
    logic [15:0] wdata;
  } mbd_par_t;

endpackage

// >>> core/mbd_data_map.sv
// Request interpreter and data map of the drive's bus slave.

module mbd_data_map
  import mbd_pkg::*;
#(
  parameter logic [7:0] SLAVE_ID = 8'h5a // Arbitrary identification value.
)
(
  input wire logic sys_clk, // System clock, 20 MHz.
  input wire logic reset, // Asynchronous reset, active high.
  input wire logic req_valid, // Request item present.
  input wire mbd_req_t req, // Request item fields.
  input wire logic frame_commit, // Frame passed its checks.
  input wire logic frame_seen, // A frame was seen on the bus.
  input wire logic frame_err, // A frame failed its checks.
  input wire logic [15:0] drive_status, // Raw drive status bits.
  input wire logic [15:0] out_freq, // Output frequency.
  input wire logic [15:0] feedback, // Feedback signal.
  input wire logic closed_loop, // Drive runs closed loop.
  input wire logic [15:0] last_err, // Last data-object error code.
  input wire logic par_ack, // Parameter access finished.
  input wire logic par_err, // Parameter access failed.
  input wire logic [15:0] par_rdata, // Parameter read value.
  output logic req_ready, // Interpreter can take an item.
  output logic rsp_valid, // Answer present, one cycle.
  output mbd_rsp_t rsp, // Answer fields.
  output mbd_cmd_t cmd, // Applied command word.
  output logic [15:0] speed_ref, // Bus speed reference.
  output logic par_valid, // Parameter access request, one cycle.
  output mbd_par_t par // Parameter access fields.
);

  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_PWAIT = 2'b10} mbd_state_t;

  mbd_state_t state_q, state_d;
  logic req_ready_q, rsp_valid_q, par_valid_q, store_nv_q;
  mbd_rsp_t rsp_q, rsp_d;
  mbd_cmd_t cmd_q;
  mbd_par_t par_q;
  logic [15:0] shadow_q, shadow_d, ref_q, ref_d, index_q, index_d;
  logic [15:0] bus_cnt_q, err_cnt_q, exc_cnt_q, slv_cnt_q, diag_q;
  logic [7:0] func_q;
  logic store_nv_d;

  // ==========================================================================
  // Request classification
  wire take = req_valid && req_ready_q;
  wire is_rdc = req.func == FC_RD_COILS;
  wire is_wrsc = req.func == FC_WR_COIL;
  wire is_wrmc = req.func == FC_WR_COILS;
  wire is_rdh = req.func == FC_RD_HOLD;
  wire is_wrsr = req.func == FC_WR_REG;
  wire is_wrmr = req.func == FC_WR_REGS;
  wire is_diag = req.func == FC_DIAG;
  wire is_evc = req.func == FC_EVT_CNT;
  wire is_sid = req.func == FC_SLAVE_ID;
  wire is_coil = is_rdc || is_wrsc || is_wrmc;
  wire is_reg = is_rdh || is_wrsr || is_wrmr;
  wire is_wr = is_wrsc || is_wrmc || is_wrsr || is_wrmr;
  wire sub_ok = (req.addr == SUB_RESTART) || (req.addr == SUB_DIAG_REG) ||
    ((req.addr >= SUB_CLEAR) && (req.addr <= SUB_SLV_MSG));
  wire supported = is_coil || is_reg || is_evc || is_sid || (is_diag && sub_ok);

  // Single writes carry one item whatever the quantity field says.
  wire [15:0] eff_qty = (is_wrsc || is_wrsr) ? 16'h0001 : req.qty;
  wire [16:0] end_adr = {1'b0, req.addr} + {1'b0, eff_qty};
  wire range_bad = is_coil ? (end_adr > COIL_END) : (is_reg && (end_adr > REG_END));
  wire value_bad = (is_coil || is_reg) &&
    ((eff_qty == 16'h0000) || (is_wrsc && (req.data != COIL_ON) && (req.data != COIL_OFF)));
  wire [7:0] exc_code = !supported ? EXC_FUNC : value_bad ? EXC_VALUE : range_bad ? EXC_ADDR : EXC_NONE;
  wire ok = exc_code == EXC_NONE;

  // ==========================================================================
  // Holding register decode; reserved numbers fall through to zero.
  // zero-based addresses
  wire [15:0] reg_num = req.addr + 16'h0001;
  wire hit_err = reg_num == REG_ERR;
  wire hit_idx = reg_num == REG_INDEX;
  wire hit_cmd = reg_num == REG_CMD;
  wire hit_ref = reg_num == REG_REF;
  wire hit_stw = reg_num == REG_STW;
  wire hit_mav = reg_num == REG_MAV;
  wire hit_par = (reg_num >= REG_PAR_FIRST) && (reg_num < REG_CMD);
  wire [15:0] par_num = reg_num / PAR_SCALE;

  wire [15:0] stw_vis = drive_status & STW_USED_MASK;
  wire [15:0] main_actual_value = closed_loop ? feedback : out_freq;
  wire [15:0] reg_rdata = hit_err ? last_err : hit_idx ? index_q : hit_cmd ? shadow_q :
    hit_ref ? ref_q : hit_stw ? stw_vis : hit_mav ? main_actual_value : 16'h0000;
  wire reg_wr = take && ok && (is_wrsr || is_wrmr);
  wire par_go = take && ok && is_reg && hit_par;

  // ==========================================================================
  // Coil image; one request item moves at most sixteen coils.
  // one bit per coil
  wire [COIL_COUNT-1:0] coil_img = {store_nv_q, main_actual_value, stw_vis, ref_q, shadow_q};
  wire [4:0] coil_n = (is_wrsc || (req.qty < 16'h0010)) ? eff_qty[4:0] : COIL_ITEM_MAX;
  wire [16:0] coil_lim = {1'b0, req.addr} + {12'h000, coil_n};
  wire [COIL_COUNT-1:0] coil_shift = coil_img >> req.addr;
  wire [15:0] coil_mask = 16'(({1'b0, 16'hffff} << coil_n) ^ {1'b1, 16'hffff});
  wire [15:0] coil_rd = coil_shift[15:0] & coil_mask;
  wire [15:0] wbits = is_wrsc ? {15'h0000, req.data == COIL_ON} : req.data;
  wire coil_wr = take && ok && (is_wrsc || is_wrmc);
  logic [COIL_COUNT-1:0] coil_new;

  // Each coil compares itself to the window; read-only coils are never stored.
  genvar gi;
  for (gi = 0; gi < COIL_COUNT; gi++)
  begin : g_coil
    wire [16:0] pos = 17'(gi);
    wire [16:0] rel = pos - {1'b0, req.addr};
    wire hit = coil_wr && ({1'b0, req.addr} <= pos) && (pos < coil_lim);
    assign coil_new[gi] = hit ? wbits[rel[3:0]] : coil_img[gi];
  end

  assign shadow_d = coil_wr ? coil_new[COIL_REF_LSB-1:COIL_CMD_LSB] : (reg_wr && hit_cmd) ? req.data : shadow_q;
  assign ref_d = coil_wr ? coil_new[COIL_STW_LSB-1:COIL_REF_LSB] : (reg_wr && hit_ref) ? req.data : ref_q;
  assign index_d = (reg_wr && hit_idx) ? req.data : index_q;
  assign store_nv_d = coil_wr ? coil_new[COIL_STORE] : store_nv_q;

  // ==========================================================================
  // Diagnostic counters; an event in the clearing cycle still counts.
  wire clr = take && ok && is_diag && ((req.addr == SUB_RESTART) || (req.addr == SUB_CLEAR));
  wire exc_ev = (take && !ok) || ((state_q == ST_PWAIT) && par_ack && par_err);
  wire slv_ev = take;
  wire [15:0] diag_data = (req.addr == SUB_DIAG_REG) ? diag_q : (req.addr == SUB_BUS_MSG) ? bus_cnt_q :
    (req.addr == SUB_BUS_ERR) ? err_cnt_q : (req.addr == SUB_EXC_CNT) ? exc_cnt_q :
    (req.addr == SUB_SLV_MSG) ? slv_cnt_q : req.data;
  wire [15:0] sid_data = {SLAVE_ID, drive_status[STW_RUNNING] ? 8'hff : 8'h00};

  wire [15:0] ok_data = is_rdc ? coil_rd : is_rdh ? reg_rdata : is_wr ? req.data :
    is_diag ? diag_data : is_evc ? slv_cnt_q : sid_data;

  // ==========================================================================
  // Sequencer: parameter items wait for the parameter store, others answer next edge.
  always_comb
  begin
    state_d = state_q;
    rsp_d = '0;
    unique case (state_q)
      ST_IDLE:
      begin
        if (par_go)
        begin
          state_d = ST_PWAIT;
        end
        else if (take)
        begin
          rsp_d.exc = !ok;
          rsp_d.code = exc_code;
          rsp_d.func = ok ? req.func : (req.func | FC_EXC_FLAG);
          rsp_d.data = ok ? ok_data : 16'h0000;
        end
      end
      ST_PWAIT:
      begin
        if (par_ack)
        begin
          state_d = ST_IDLE;
          rsp_d.exc = par_err;
          rsp_d.code = par_err ? EXC_DEVICE : EXC_NONE;
          rsp_d.func = par_err ? (func_q | FC_EXC_FLAG) : func_q;
          rsp_d.data = par_err ? 16'h0000 : par_rdata;
        end
      end
    endcase
  end

  // State, answer and handshake flops.
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= ST_IDLE;
      req_ready_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_q <= '0;
      func_q <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      req_ready_q <= state_d == ST_IDLE;
      rsp_valid_q <= (take && !par_go) || ((state_q == ST_PWAIT) && par_ack);
      rsp_q <= rsp_d;
      func_q <= take ? req.func : func_q;
    end
  end

  // Parameter request; the store choice travels with every access.
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      par_valid_q <= 1'b0;
      par_q <= '0;
    end
    else
    begin
      par_valid_q <= par_go;
      if (par_go)
      begin
        par_q <= '{write: is_wrsr || is_wrmr, store_nv: store_nv_q, num: par_num, index: index_q,
          wdata: req.data};
      end
    end
  end

  // Written words; the command word applies only at frame acceptance so a
  // half-written word never reaches the drive.
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      shadow_q <= 16'h0000;
      ref_q <= 16'h0000;
      index_q <= 16'h0000;
      store_nv_q <= 1'b0;
      cmd_q <= '0;
    end
    else
    begin
      shadow_q <= shadow_d;
      ref_q <= ref_d;
      index_q <= index_d;
      store_nv_q <= store_nv_d;
      if (frame_commit)
      begin
        cmd_q <= mbd_cmd_t'(shadow_d);
      end
    end
  end

  // Counters wrap at full scale; software is expected to clear them.
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      bus_cnt_q <= 16'h0000;
      err_cnt_q <= 16'h0000;
      exc_cnt_q <= 16'h0000;
      slv_cnt_q <= 16'h0000;
      diag_q <= 16'h0000;
    end
    else
    begin
      bus_cnt_q <= (clr ? 16'h0000 : bus_cnt_q) + {15'h0000, frame_seen};
      err_cnt_q <= (clr ? 16'h0000 : err_cnt_q) + {15'h0000, frame_err};
      exc_cnt_q <= (clr ? 16'h0000 : exc_cnt_q) + {15'h0000, exc_ev};
      slv_cnt_q <= (clr ? 16'h0000 : slv_cnt_q) + {15'h0000, slv_ev};
      diag_q <= (clr ? 16'h0000 : diag_q) | {14'h0000, frame_err, exc_ev};
    end
  end

  assign req_ready = req_ready_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp = rsp_q;
  assign cmd = cmd_q;
  assign speed_ref = ref_q;
  assign par_valid = par_valid_q;
  assign par = par_q;

endmodule

// >>> sim/mbd_data_map_checker.sv
// Port assertions for the drive data map.
module mbd_data_map_checker
  import mbd_pkg::*;
(
  input wire logic sys_clk, // Clock.
  input wire logic reset, // Reset.
  input wire logic req_valid, // Item present.
  input wire mbd_req_t req, // Item fields.
  input wire logic frame_commit, // Frame accepted.
  input wire logic [15:0] drive_status, // Raw status.
  input wire logic par_ack, // Access done.
  input wire logic req_ready, // Can take.
  input wire logic rsp_valid, // Answer strobe.
  input wire mbd_rsp_t rsp, // Answer.
  input wire mbd_cmd_t cmd, // Command word.
  input wire logic par_valid, // Access strobe.
  input wire mbd_par_t par // Access fields.
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // All checks share one clock and go quiet in reset.
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // A coil-read take or a parameter acknowledge causes an answer; span is kept wide so it cannot wrap.
  wire logic take = req_valid && req_ready;
  wire logic [16:0] span = {1'b0, req.addr} + {1'b0, req.qty};
  a_coil_answer: assert property (take && req.func == FC_RD_COILS |=> rsp_valid)
    else $error("coil read not answered");
  a_status_mask: assert property (take && req.func == FC_RD_COILS && req.addr == 16'h20
    && req.qty == 16'h10 |=> rsp.data == ($past(drive_status) & STW_USED_MASK))
    else $error("status word read wrong");
  a_bad_func: assert property (take && req.func == 8'h07
    |=> rsp_valid && rsp.exc && rsp.code == EXC_FUNC && rsp.func == 8'h87)
    else $error("unsupported function not refused");
  a_range_exc: assert property (take && req.func == FC_RD_HOLD && req.qty != 16'h0 && span > REG_END
    |=> rsp_valid && rsp.code == EXC_ADDR)
    else $error("range overrun not refused");
  a_par_number: assert property (take && req.func == FC_RD_HOLD && req.qty == 16'h1
    && req.addr >= 16'h9 && req.addr < 16'hc34f |=> par_valid && par.num == ($past(req.addr) + 16'h1) / PAR_SCALE)
    else $error("parameter number wrong");
  a_par_hold: assert property (par_valid |-> !req_ready ##1 !par_valid)
    else $error("parameter access not held off");
  a_ack_answer: assert property (par_ack |=> rsp_valid && req_ready)
    else $error("parameter answer late");
  a_cmd_commit: assert property (!frame_commit |=> $stable(cmd))
    else $error("command changed without commit");
endmodule

// >>> sim/mbd_par_model.sv
// Parameter store model answering the data map's access requests.
module mbd_par_model
  import mbd_pkg::*;
(
  input wire logic sys_clk, // Clock.
  input wire logic reset, // Reset.
  input wire logic slow, // Stretch the answer.
  input wire logic par_valid, // Access strobe.
  input wire mbd_par_t par, // Access fields.
  output logic par_ack, // Access done.
  output logic par_err, // Access failed.
  output logic [15:0] par_rdata // Read word.
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // Parameter 100 plays a failing store so the fault path is reachable.
  localparam logic [15:0] BAD_NUM = 16'h64;
  logic [3:0] wait_q;
  logic [15:0] num_q;
  // Read data toggles outside the answer, so a stale sample cannot pass.
  // one word per number
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      wait_q <= 4'h0;
      par_ack <= 1'b0;
      par_err <= 1'b0;
      par_rdata <= 16'h0;
    end
    else
    begin
      par_ack <= wait_q == 4'h1;
      par_err <= wait_q == 4'h1 && num_q == BAD_NUM;
      par_rdata <= wait_q == 4'h1 ? num_q ^ 16'hf0f : ~par_rdata;
      if (par_valid)
        num_q <= par.num;
      wait_q <= par_valid ? (slow ? 4'h9 : 4'h1) : wait_q - (wait_q != 4'h0);
    end
  end
endmodule

// >>> sim/tb_modbus_drive_data_map.sv
// Self-checking bench for the drive data map.
module tb_modbus_drive_data_map
  import mbd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    mbd_req_t q;
    logic [7:0] code;
    logic dchk;
    logic [15:0] d;
  } mbd_row_t;
  logic sys_clk = 1'b0, reset = 1'b1, req_valid = 1'b0, frame_commit = 1'b0;
  logic frame_seen = 1'b0, frame_err = 1'b0, closed_loop = 1'b0, slow = 1'b0;
  logic [15:0] drive_status = 16'hffff, out_freq = 16'h1357, feedback = 16'h2468, last_err = 16'hc1;
  mbd_req_t req = '0;
  logic par_ack, par_err, req_ready, rsp_valid, par_valid;
  logic [15:0] par_rdata, speed_ref;
  mbd_rsp_t rsp;
  mbd_cmd_t cmd;
  mbd_par_t par, last_par;
  mbd_row_t rows[$];
  logic [15:0] subs[7] = '{16'h1, 16'h2, 16'ha, 16'hb, 16'hc, 16'hd, 16'he};
  int fail_count = 0, n_tests = 0, cyc = 0;
  mbd_data_map u_dut (.sys_clk, .reset, .req_valid, .req, .frame_commit, .frame_seen, .frame_err,
    .drive_status, .out_freq, .feedback, .closed_loop, .last_err, .par_ack, .par_err, .par_rdata,
    .req_ready, .rsp_valid, .rsp, .cmd, .speed_ref, .par_valid, .par);
  mbd_par_model u_par (.sys_clk, .reset, .slow, .par_valid, .par, .par_ack, .par_err, .par_rdata);
  // ==========
  // Clock, hang guard and a record of the last parameter access.
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cyc++;
    if (par_valid === 1'b1)
      last_par <= par;
    if (cyc == 20000)
    begin
      fail_count++;
      test_done;
    end
  end
  task test_done;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_tests++;
    if (s !== e)
    begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic add(input logic [7:0] f, input logic [15:0] a, n, d, e, input logic k, input logic [7:0] c);
    rows.push_back('{'{f, a, n, d}, c, k, e});
  endtask
  // The request stays up until a sampled ready takes it; the answer wait is bounded.
  task automatic xfer(input mbd_req_t r);
    int k;
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req <= r;
    @(negedge sys_clk);
    while (req_ready !== 1'b1)
      @(negedge sys_clk);
    @(posedge sys_clk);
    req_valid <= 1'b0;
    @(negedge sys_clk);
    for (k = 0; rsp_valid !== 1'b1 && k < 40; k++)
      @(negedge sys_clk);
    chk("rsp_valid", rsp_valid, 1'b1);
  endtask
  task automatic dq(input logic [15:0] s, e);
    xfer('{FC_DIAG, s, 16'h1, 16'h0});
    chk("diag", rsp.data, e);
  endtask
  // Each pulse lasts exactly one cycle.
  task automatic pulse(input logic c, input logic f);
    @(posedge sys_clk);
    frame_commit <= c;
    frame_seen <= f;
    frame_err <= f;
    @(posedge sys_clk);
    {frame_commit, frame_seen, frame_err} <= 3'h0;
    @(negedge sys_clk);
  endtask
  initial
  begin
    add(8'h1, 16'h20, 16'h10, 16'h0, 16'hef8f, 1'b1, 8'h0);
    add(8'h1, 16'h30, 16'h10, 16'h0, 16'h1357, 1'b1, 8'h0);
    add(8'h1, 16'h22, 16'h4, 16'h0, 16'h3, 1'b1, 8'h0);
    add(8'h7, 16'h0, 16'h1, 16'h0, 16'h0, 1'b0, 8'h1);
    add(8'h1, 16'h40, 16'h2, 16'h0, 16'h0, 1'b0, 8'h2);
    add(8'h5, 16'h40, 16'h1, 16'h1234, 16'h0, 1'b0, 8'h3);
    add(8'h5, 16'h40, 16'h1, 16'hff00, 16'h0, 1'b0, 8'h0);
    add(8'h1, 16'h40, 16'h1, 16'h0, 16'h1, 1'b1, 8'h0);
    add(8'h3, 16'h6, 16'h1, 16'h0, 16'hc1, 1'b1, 8'h0);
    add(8'h3, 16'h0, 16'h1, 16'h0, 16'h0, 1'b1, 8'h0);
    add(8'h6, 16'h8, 16'h1, 16'h3, 16'h0, 1'b0, 8'h0);
    add(8'h3, 16'h8, 16'h1, 16'h0, 16'h3, 1'b1, 8'h0);
    add(8'h3, 16'hc417, 16'h1, 16'h0, 16'hef8f, 1'b1, 8'h0);
    add(8'h3, 16'hc421, 16'h2, 16'h0, 16'h0, 1'b0, 8'h2);
    add(8'h3, 16'h13, 16'h1, 16'h0, 16'hf0d, 1'b1, 8'h0);
    add(8'h3, 16'h3e7, 16'h1, 16'h0, 16'h0, 1'b0, 8'h4);
    add(8'h6, 16'hc345, 16'h1, 16'h1111, 16'h0, 1'b0, 8'h0);
    add(8'h11, 16'h0, 16'h1, 16'h0, 16'h5aff, 1'b1, 8'h0);
    add(8'hb, 16'h0, 16'h1, 16'h0, 16'h12, 1'b1, 8'h0);
    add(8'h8, 16'hf, 16'h1, 16'h0, 16'h0, 1'b0, 8'h1);
    add(8'h10, 16'hc359, 16'h1, 16'h8000, 16'h0, 1'b0, 8'h0);
    add(8'hf, 16'h0, 16'h10, 16'ha5c3, 16'h0, 1'b0, 8'h0);
    add(8'h1, 16'h0, 16'h10, 16'h0, 16'ha5c3, 1'b1, 8'h0);
    repeat (12) @(posedge sys_clk);
    chk("ready in reset", req_ready, 1'b0);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    foreach (rows[i])
    begin
      xfer(rows[i].q);
      chk("code", rsp.code, rows[i].code);
      chk("func", rsp.func, rows[i].q.func | (rows[i].code != 8'h0 ? FC_EXC_FLAG : 8'h0));
      if (rows[i].dchk)
        chk("data", rsp.data, rows[i].d);
      $display("row %0d done", i);
    end
    chk("par", {last_par.write, last_par.store_nv, last_par.num}, {2'h3, 16'h1387});
    chk("par index", {last_par.index, last_par.wdata}, {16'h3, 16'h1111});
    chk("cmd early", cmd, 16'h0);
    pulse(1'b1, 1'b0);
    chk("cmd", cmd, 16'ha5c3);
    chk("stops", {cmd.no_dc_brake, cmd.start, cmd.setup_sel, cmd.reverse}, 5'h0b);
    chk("speed_ref", speed_ref, 16'h8000);
    $display("command test done");
    @(posedge sys_clk);
    closed_loop <= 1'b1;
    xfer('{FC_RD_HOLD, 16'hc421, 16'h1, 16'h0});
    chk("feedback", rsp.data, 16'h2468);
    @(posedge sys_clk);
    slow <= 1'b1;
    xfer('{FC_RD_HOLD, 16'h13, 16'h1, 16'h0});
    chk("slow par", rsp.data, 16'hf0d);
    foreach (subs[i])
    begin
      xfer('{FC_DIAG, subs[i], 16'h1, 16'h0});
      chk("sub", rsp.exc, 1'b0);
    end
    dq(16'ha, 16'h0);
    pulse(1'b0, 1'b1);
    dq(16'hb, 16'h1);
    dq(16'hc, 16'h1);
    dq(16'h2, 16'h2);
    $display("diagnostic test done");
    @(posedge sys_clk);
    reset <= 1'b1;
    @(negedge sys_clk);
    chk("cmd reset", cmd, 16'h0);
    chk("ref reset", speed_ref, 16'h0);
    chk("ready reset", req_ready, 1'b0);
    @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    xfer('{FC_RD_COILS, 16'h20, 16'h10, 16'h0});
    chk("after reset", rsp.data, 16'hef8f);
    $display("reset test done");
    test_done;
  end
endmodule
bind mbd_data_map mbd_data_map_checker u_chk (.sys_clk, .reset, .req_valid, .req, .frame_commit,
  .drive_status, .par_ack, .req_ready, .rsp_valid, .rsp, .cmd, .par_valid, .par);
